// ### hdl/rbs_top.sv
// Behaviour
// RULE1 - Ignore request one lows under 50 ns
// RULE2 - Ignore request two lows under 20 ms
// RULE3 - Hold reset 40-200 ms after request release
// RULE4 - Check battery at power-up and daily
// RULE5 - Low battery sets flag bit four
// RULE6 - Flag stays until a later check passes
// RULE7 - No battery checks without main supply
// RULE8 - Power application clears watchdog, alarms, tests
// RULE9 - Initial power-up also clears read hold
// RULE10 - Reset clears holds, test, alarms, watchdog
// RULE11 - Power-down keeps read hold and alarms
// RULE12 - Ignore request inputs while reset stretches
// RULE13 - Power-up gives same reset pulse length
// RULE14 - Either request input alone starts reset
`timescale 1ns/100ps

module rbs_top
  import rbs_pkg::*;
#(
  parameter int unsigned     REQ2_CYCLES    = REQ2_CYC,     // Request two filter length
  parameter int unsigned     STRETCH_CYCLES = STRETCH_CYC,  // Reset stretch length
  parameter longint unsigned CHECK_CYCLES   = CHECK_CYC     // Battery check period
)
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Reset request inputs, active low
  input  wire logic        reset_request_one_n_i,
  input  wire logic        reset_request_two_n_i,
  // Supply and battery monitors
  input  wire logic        power_good_i,
  input  wire logic        battery_ok_i,
  // Processor reset, open drain
  output logic             proc_reset_n_o,
  output logic             proc_reset_oe_o,
  // Status and interrupt
  output logic             battery_low_flag_o,
  output logic             irq_o
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  rbs_state_t        state;               // Reset sequencer state
  logic [31:0]       stretch_cnt;         // Cycles left in stretch
  logic              req_one_ok;          // Filtered request one
  logic              req_two_ok;          // Filtered request two
  logic              trig_one;            // Request one started hold
  logic              trig_two;            // Request two started hold
  logic              req_event;           // Accepted request, one cycle
  logic              pwr_q;               // Supply level last cycle
  logic              pwr_rise;            // Supply came up
  logic              pwr_fall;            // Supply went down
  logic [63:0]       period_cnt;          // Battery check period
  logic              check_now;           // Battery sampled this cycle
  logic              battery_low_flag;    // Sticky battery status
  logic              write_hold;          // Clock update hold for writes
  logic              read_hold;           // Clock update hold for reads
  logic              frequency_test;      // Test output enable
  logic              alarm_flag_enable;   // Alarm interrupt enable
  logic              alarm_backup_enable; // Alarm in back-up enable
  logic              watchdog_steer;      // Watchdog output steering
  logic [4:0]        watchdog_multiplier; // Watchdog timeout multiplier
  logic [1:0]        watchdog_resolution; // Watchdog timeout resolution
  logic [IRQ_W-1:0]  irq_stat;            // Sticky events
  logic [IRQ_W-1:0]  irq_en;              // Event enables
  logic [IRQ_W-1:0]  irq_set;             // Events this cycle
  logic              bus_req;             // Fresh bus access
  logic              bus_wr;              // Write with low lane on
  logic [31:0]       next_rdata;          // Read mux

  // ----------------------------------------------------------------
  // Request filters
  // ----------------------------------------------------------------
  rbs_req_filter #(.THRESH(REQ1_CYC)) u_filt_one (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .req_n_i   (reset_request_one_n_i),
    .valid_o   (req_one_ok)
  );

  rbs_req_filter #(.THRESH(REQ2_CYCLES)) u_filt_two (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .req_n_i   (reset_request_two_n_i),
    .valid_o   (req_two_ok)
  );

  // ----------------------------------------------------------------
  // Supply edge detection
  // ----------------------------------------------------------------
  // Starts low so a supply already good at release counts as power-up
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      pwr_q <= 1'b0;
    else
      pwr_q <= power_good_i;
  end

  assign pwr_rise = power_good_i && !pwr_q;
  assign pwr_fall = !power_good_i && pwr_q;

  // Requests count only in idle, so a stretch is never restarted
  assign req_event = (state == ST_IDLE) && power_good_i && (req_one_ok || req_two_ok);  // RULE12 RULE14

  // ----------------------------------------------------------------
  // Reset sequencer
  // ----------------------------------------------------------------
  // Supply loss overrides everything; reset is held through back-up
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      state       <= ST_PWRDN;
      stretch_cnt <= 32'h0;
      trig_one    <= 1'b0;
      trig_two    <= 1'b0;
    end
    else if (!power_good_i)
      state <= ST_PWRDN;
    else
    begin
      case (state)
        ST_IDLE:
        begin
          // Remember which line fired, wait for it alone
          if (req_event)
          begin
            trig_one <= req_one_ok;  // RULE14
            trig_two <= req_two_ok;
            state    <= ST_HOLD;
          end
        end
        ST_HOLD:
        begin
          // Stretch starts once the firing lines are back high
          if ((!trig_one || reset_request_one_n_i) && (!trig_two || reset_request_two_n_i))
          begin
            stretch_cnt <= STRETCH_CYCLES - 1;  // RULE3
            state       <= ST_STRETCH;
          end
        end
        ST_STRETCH:
        begin
          // Inputs not looked at here
          if (stretch_cnt == 32'h0)  // RULE12
            state <= ST_IDLE;
          else
            stretch_cnt <= stretch_cnt - 32'h1;
        end
        ST_PWRDN:
        begin
          // Supply is good again: same pulse as a request
          stretch_cnt <= STRETCH_CYCLES - 1;  // RULE13
          state       <= ST_STRETCH;
        end
        default:
          state <= ST_PWRDN;
      endcase
    end
  end

  // Open-drain reset: pull low in every state but idle
  assign proc_reset_n_o  = 1'b0;
  assign proc_reset_oe_o = (state != ST_IDLE);  // RULE3 RULE13

  // ----------------------------------------------------------------
  // Battery monitor
  // ----------------------------------------------------------------
  // Period restarts at each power-up and only runs on main supply
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i || !power_good_i || pwr_q != power_good_i)
      period_cnt <= 64'h0;
    else if (period_cnt == CHECK_CYCLES - 1)
      period_cnt <= 64'h0;
    else
      period_cnt <= period_cnt + 64'h1;
  end

  // Check on power-up and at each period end, never in back-up
  assign check_now = power_good_i && (pwr_rise || period_cnt == CHECK_CYCLES - 1);  // RULE4 RULE7

  // Flag follows the latest check and holds in between
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      battery_low_flag <= 1'b0;
    else if (check_now)
      battery_low_flag <= !battery_ok_i;  // RULE5 RULE6
  end

  assign battery_low_flag_o = battery_low_flag;

  // ----------------------------------------------------------------
  // Control bits with their default values
  // ----------------------------------------------------------------
  assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  // Writes lost while the supply is out, as in back-up
  assign bus_wr  = bus_req && wb_we_i && wb_sel_i[0] && power_good_i;

  // Event order: initial power-up, power edges, reset, then bus writes
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      // Initial power-up clears read hold too
      write_hold          <= CTRL_RST[CTL_WHOLD];  // RULE8 RULE9
      read_hold           <= CTRL_RST[CTL_RHOLD];
      frequency_test      <= CTRL_RST[CTL_FTEST];
      alarm_flag_enable   <= CTRL_RST[CTL_AFE];
      alarm_backup_enable <= CTRL_RST[CTL_ABE];
    end
    else if (pwr_fall)
    begin
      // Read hold and alarm enables survive power-down
      write_hold     <= 1'b0;  // RULE11
      frequency_test <= 1'b0;
    end
    else if (pwr_rise)
    begin
      // Later power-up: alarms off, read hold kept
      write_hold          <= 1'b0;  // RULE8 RULE11
      frequency_test      <= 1'b0;
      alarm_flag_enable   <= 1'b0;
      alarm_backup_enable <= 1'b0;
    end
    else if (req_event)
    begin
      write_hold          <= 1'b0;  // RULE10
      read_hold           <= 1'b0;
      frequency_test      <= 1'b0;
      alarm_flag_enable   <= 1'b0;
      alarm_backup_enable <= 1'b0;
    end
    else if (bus_wr && wb_adr_i == ADR_CTRL)
    begin
      write_hold          <= wb_dat_i[CTL_WHOLD];
      read_hold           <= wb_dat_i[CTL_RHOLD];
      frequency_test      <= wb_dat_i[CTL_FTEST];
      alarm_flag_enable   <= wb_dat_i[CTL_AFE];
      alarm_backup_enable <= wb_dat_i[CTL_ABE];
    end
  end

  // Watchdog fields cleared by every supply and reset event
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i || pwr_fall || pwr_rise || req_event)
    begin
      watchdog_steer      <= WDOG_RST[WDG_STEER];  // RULE8 RULE10 RULE11
      watchdog_multiplier <= WDOG_RST[WDG_MUL_LSB +: 5];
      watchdog_resolution <= WDOG_RST[WDG_RES_LSB +: 2];
    end
    else if (bus_wr && wb_adr_i == ADR_WDOG)
    begin
      watchdog_steer      <= wb_dat_i[WDG_STEER];
      watchdog_multiplier <= wb_dat_i[WDG_MUL_LSB +: 5];
      watchdog_resolution <= wb_dat_i[WDG_RES_LSB +: 2];
    end
  end

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  assign irq_set[IRQ_BATT]  = check_now && !battery_ok_i;
  assign irq_set[IRQ_RESET] = req_event;
  assign irq_set[IRQ_PFAIL] = pwr_fall;

  // Set beats a clear in the same cycle
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      irq_stat <= IRQ_RST;
    else if (bus_wr && wb_adr_i == ADR_IRQ_CLR)
      irq_stat <= (irq_stat & ~wb_dat_i[IRQ_W-1:0]) | irq_set;
    else
      irq_stat <= irq_stat | irq_set;
  end

  // Enable register
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      irq_en <= IRQ_RST;
    else if (bus_wr && wb_adr_i == ADR_IRQ_EN)
      irq_en <= wb_dat_i[IRQ_W-1:0];
  end

  assign irq_o = |(irq_stat & irq_en);

  // ----------------------------------------------------------------
  // Wishbone read and acknowledge
  // ----------------------------------------------------------------
  // Unmapped and write-only addresses read zero
  always_comb
  begin
    next_rdata = 32'h0;
    case (wb_adr_i)
      ADR_FLAGS:    next_rdata[FLG_BATT_LOW] = battery_low_flag;
      ADR_CTRL:     next_rdata[4:0] = {alarm_backup_enable, alarm_flag_enable,
                                       frequency_test, read_hold, write_hold};
      ADR_WDOG:     next_rdata[7:0] = {watchdog_steer, watchdog_multiplier,
                                       watchdog_resolution};
      ADR_IRQ_STAT: next_rdata[IRQ_W-1:0] = irq_stat;
      ADR_IRQ_EN:   next_rdata[IRQ_W-1:0] = irq_en;
      default:      next_rdata = 32'h0;
    endcase
  end

  // One wait state; ack drops the cycle after it is given
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end
    else
    begin
      wb_ack_o <= bus_req;
      if (bus_req && !wb_we_i)
        wb_dat_o <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence seq_stretch_end;
    (state == ST_STRETCH) && (stretch_cnt == 32'h0) && power_good_i;
  endsequence

  sequence seq_req_taken;
    req_event;
  endsequence

  AST_STRETCH_RELEASE: assert property (@(posedge clk_i) disable iff (sys_rst_i)  // RULE3
    seq_stretch_end |=> (state == ST_IDLE) && !proc_reset_oe_o)
    else $error("reset not released at end of stretch");

  // Sampled reset excluded: the release edge itself moves nothing yet
  AST_STRETCH_LOAD: assert property (@(posedge clk_i) disable iff (sys_rst_i)  // RULE13
    !sys_rst_i && (state == ST_PWRDN) && power_good_i |=> (state == ST_STRETCH)
      && (stretch_cnt == STRETCH_CYCLES - 1) && proc_reset_oe_o)
    else $error("power-up stretch not loaded");

  AST_IGNORE_REQ: assert property (@(posedge clk_i) disable iff (sys_rst_i)  // RULE12
    (state == ST_STRETCH) && (stretch_cnt != 32'h0) && power_good_i
      |=> (state == ST_STRETCH) && (stretch_cnt == $past(stretch_cnt) - 32'h1))
    else $error("stretch disturbed");

  AST_EITHER_REQ: assert property (@(posedge clk_i) disable iff (sys_rst_i)  // RULE14
    (state == ST_IDLE) && power_good_i && (req_one_ok ^ req_two_ok)
      |=> (state == ST_HOLD) && proc_reset_oe_o)
    else $error("single request did not start reset");

  AST_BATT_SET: assert property (@(posedge clk_i) disable iff (sys_rst_i)  // RULE5
    check_now && !battery_ok_i |=> battery_low_flag ##1 (battery_low_flag || $past(check_now)))
    else $error("battery low not flagged");

  AST_BATT_KEEP: assert property (@(posedge clk_i) disable iff (sys_rst_i)  // RULE6
    !check_now |=> battery_low_flag == $past(battery_low_flag))
    else $error("battery flag changed without a check");

  AST_NO_CHECK_BACKUP: assert property (@(posedge clk_i) disable iff (sys_rst_i)  // RULE7
    !power_good_i |-> !check_now && (period_cnt == 64'h0 || pwr_fall))
    else $error("battery check during back-up");

  AST_REQ_CLEARS: assert property (@(posedge clk_i) disable iff (sys_rst_i)  // RULE10
    seq_req_taken |=> !read_hold && !write_hold && !frequency_test
      && !alarm_flag_enable && !watchdog_steer && (watchdog_multiplier == 5'h0))
    else $error("reset defaults not applied");

  AST_PWRDN_KEEP: assert property (@(posedge clk_i) disable iff (sys_rst_i)  // RULE11
    pwr_fall |=> (read_hold == $past(read_hold))
      && (alarm_flag_enable == $past(alarm_flag_enable)) && !write_hold && !frequency_test)
    else $error("power-down defaults wrong");

  AST_PWRUP_CLEARS: assert property (@(posedge clk_i) disable iff (sys_rst_i)  // RULE8
    pwr_rise |=> !alarm_flag_enable && !alarm_backup_enable && !watchdog_steer
      && (read_hold == $past(read_hold)))
    else $error("power-up defaults wrong");

endmodule : rbs_top

// ### hdl/rbs_pkg.sv
package rbs_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS  = 4;         // 250 MHz system clock
  localparam int unsigned REQ1_REJECT_NS = 50;        // Shorter lows are noise
  localparam int unsigned REQ1_CYC       = (REQ1_REJECT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned REQ2_REJECT_MS = 20;        // Shorter lows are noise
  localparam int unsigned REQ2_CYC       = (REQ2_REJECT_MS * 1000000) / CLK_PERIOD_NS;
  localparam int unsigned STRETCH_MS     = 40;        // Least reset stretch
  localparam int unsigned STRETCH_CYC    = (STRETCH_MS * 1000000) / CLK_PERIOD_NS;
  localparam longint unsigned CHECK_HOURS = 24;       // Battery check period
  localparam longint unsigned CHECK_CYC  =
    (CHECK_HOURS * 64'd3600 * 64'd1000000000) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADR_FLAGS    = 8'h00;        // Battery flag
  localparam logic [7:0] ADR_CTRL     = 8'h04;        // Hold, test, alarm enables
  localparam logic [7:0] ADR_WDOG     = 8'h08;        // Watchdog fields
  localparam logic [7:0] ADR_IRQ_STAT = 8'h0C;        // Sticky events, read only
  localparam logic [7:0] ADR_IRQ_EN   = 8'h10;        // Interrupt enables
  localparam logic [7:0] ADR_IRQ_CLR  = 8'h14;        // Write one to clear

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned FLG_BATT_LOW  = 4;
  localparam int unsigned CTL_WHOLD     = 0;
  localparam int unsigned CTL_RHOLD     = 1;
  localparam int unsigned CTL_FTEST     = 2;
  localparam int unsigned CTL_AFE       = 3;
  localparam int unsigned CTL_ABE       = 4;
  localparam int unsigned WDG_RES_LSB   = 0;
  localparam int unsigned WDG_MUL_LSB   = 2;
  localparam int unsigned WDG_STEER     = 7;
  localparam int unsigned IRQ_BATT      = 0;
  localparam int unsigned IRQ_RESET     = 1;
  localparam int unsigned IRQ_PFAIL     = 2;
  localparam int unsigned IRQ_W         = 3;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [4:0]       CTRL_RST = 5'h00;
  localparam logic [7:0]       WDOG_RST = 8'h00;
  localparam logic [IRQ_W-1:0] IRQ_RST  = 3'h0;

  // Sequencer states, one-hot
  typedef enum logic [3:0] {
    ST_IDLE    = 4'h1,
    ST_HOLD    = 4'h2,
    ST_STRETCH = 4'h4,
    ST_PWRDN   = 4'h8
  } rbs_state_t;

endpackage : rbs_pkg

// ### hdl/rbs_req_filter.sv
`timescale 1ns/100ps

module rbs_req_filter
  import rbs_pkg::*;
#(
  parameter int unsigned THRESH = 13
)
(
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic sys_rst_i,
  // Request line, active low
  input  wire logic req_n_i,
  // Qualified request
  output logic      valid_o
);

  // ----------------------------------------------------------------
  // Low-time counter
  // ----------------------------------------------------------------
  logic [31:0] low_cnt;  // Consecutive low cycles, saturates

  // Any high sample restarts the count, so glitches never add up
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      low_cnt <= 32'h0;
    else if (req_n_i)
      low_cnt <= 32'h0;
    else if (low_cnt != THRESH)
      low_cnt <= low_cnt + 32'h1;
  end

  // Request counts once the line was low long enough
  assign valid_o = (low_cnt == THRESH);  // RULE1 RULE2

  // A qualified request is only ever seen after THRESH low cycles
  AST_FILT_MIN_LOW: assert property (@(posedge clk_i) disable iff (sys_rst_i)  // RULE1
    $rose(valid_o) |-> ($past(low_cnt) == THRESH - 1) && !$past(req_n_i))
    else $error("request qualified before minimum low time");

endmodule : rbs_req_filter

// ### sim/rbs_host_model.sv
`timescale 1ns/100ps

// ----------------------------------------------------------------
// Host model driving both reset request lines
// ----------------------------------------------------------------
module rbs_host_model
(
  // Clock
  input  wire logic clk_i,
  // Request lines, active low
  output logic      req_one_n_o,
  output logic      req_two_n_o
);
  // Idle high, as the pull-ups leave the lines
  initial
  begin
    req_one_n_o = 1'b1;
    req_two_n_o = 1'b1;
  end

  // One low pulse, changed only just after a rising edge
  task automatic pulse(input bit line, input int cycles);
    @(posedge clk_i);
    if (line)
      req_two_n_o <= 1'b0;
    else
      req_one_n_o <= 1'b0;
    repeat (cycles) @(posedge clk_i);
    req_one_n_o <= 1'b1;
    req_two_n_o <= 1'b1;
  endtask : pulse
endmodule : rbs_host_model

// ### sim/rbs_top_bench.sv
`timescale 1ns/100ps

module rbs_top_bench
  import rbs_pkg::*;
();
  // ----------------------------------------------------------------
  // Shortened counts, so the run stays brief
  // ----------------------------------------------------------------
  localparam int P_REQ2 = 20;
  localparam int P_STR  = 30;
  localparam int P_CHK  = 100;

  logic        clk_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'h0;
  logic [31:0] dat = 32'h0;
  logic        power_good = 1'b1;
  logic        battery_ok = 1'b1;
  logic        req_one_n;
  logic        req_two_n;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        proc_reset_n_o;
  logic        proc_reset_oe_o;
  logic        flag;
  logic        irq;
  logic [31:0] q;
  logic [31:0] d;
  int          miscompares = 0;
  int          n_compared = 0;
  int          m_ctrl;                 // Model of the control bits

  // 250 MHz clock
  always #2 clk_i = ~clk_i;

  rbs_top #(.REQ2_CYCLES(P_REQ2), .STRETCH_CYCLES(P_STR), .CHECK_CYCLES(P_CHK)) i_rbs_top (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .reset_request_one_n_i(req_one_n), .reset_request_two_n_i(req_two_n),
    .power_good_i(power_good), .battery_ok_i(battery_ok), .proc_reset_n_o(proc_reset_n_o),
    .proc_reset_oe_o(proc_reset_oe_o), .battery_low_flag_o(flag), .irq_o(irq));

  rbs_host_model i_rbs_host_model (.clk_i(clk_i), .req_one_n_o(req_one_n),
    .req_two_n_o(req_two_n));

  // ----------------------------------------------------------------
  // Report and compare helpers
  // ----------------------------------------------------------------
  task automatic close_out();
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_compared++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  // Classic cycle: hold until ack is sampled high, then release
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] dd);
    int n;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    sel <= 4'hF;
    dat <= dd;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 16);
    chk(n < 16, 1'b1, "no ack");
    // A missing ack ends the run
    if (n >= 16)
      close_out();
    else
    begin
      q = wb_dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      we  <= 1'b0;
    end
  endtask : wb

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string m);
    wb(1'b0, a, 32'h0);
    chk(q, e, m);
  endtask : rd

  // Length of a reset pulse, a loose figure of four cycles allowed
  task automatic oe_len(input string m);
    int n;
    n = 0;
    chk(proc_reset_n_o, 1'b0, "reset drive level");
    while (proc_reset_oe_o === 1'b1 && n < 400)
    begin
      @(posedge clk_i);
      n++;
    end
    chk(n >= P_STR && n <= P_STR + 4, 1'b1, m);
    // A reset that never ends is a hang
    if (n >= 400)
      close_out();
  endtask : oe_len

  // Bounded wait for the battery flag; a timeout ends the run
  task automatic wait_flag(input logic v);
    int n;
    n = 0;
    while (flag !== v && n < P_CHK + 20)
    begin
      @(posedge clk_i);
      n++;
    end
    if (flag !== v)
    begin
      chk(flag, v, "flag wait timed out");
      close_out();
    end
  endtask : wait_flag

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    void'($urandom(32'h7f408333));
    repeat (12) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    @(posedge clk_i);
    oe_len("power-up pulse");
    rd(ADR_CTRL, 32'h0, "ctrl after power-up");
    rd(ADR_WDOG, 32'h0, "watchdog after power-up");
    rd(8'h20, 32'h0, "unmapped read");
    $display("test power_up done");
    // Short pulses refused, long ones accepted, each line alone
    for (int k = 0; k < 2; k++)
    begin
      d = $urandom;
      m_ctrl = d & 32'h1F;
      wb(1'b1, ADR_CTRL, d);
      wb(1'b1, ADR_WDOG, d);
      rd(ADR_CTRL, m_ctrl, "ctrl write");
      i_rbs_host_model.pulse(k, k ? $urandom_range(1, P_REQ2 - 4) : $urandom_range(1, 11));
      repeat (4) @(posedge clk_i);
      chk(proc_reset_oe_o, 1'b0, "short pulse");
      i_rbs_host_model.pulse(k, k ? 5 * P_REQ2 : 60);
      oe_len("request pulse");
      m_ctrl = 0;
      rd(ADR_CTRL, m_ctrl, "ctrl after request");
      rd(ADR_WDOG, 32'h0, "watchdog after request");
      wb(1'b0, ADR_IRQ_STAT, 32'h0);
      chk(q & 32'h2, 32'h2, "request event");
      wb(1'b1, ADR_IRQ_CLR, 32'h7);
    end
    $display("test requests done");
    // Activity during the stretch starts nothing new
    i_rbs_host_model.pulse(1'b0, 60);
    repeat (3) @(posedge clk_i);
    i_rbs_host_model.pulse(1'b0, 20);
    repeat (P_STR) @(posedge clk_i);
    chk(proc_reset_oe_o, 1'b0, "request during stretch");
    $display("test stretch_ignore done");
    // Power cycle keeps read hold only
    d = $urandom;
    wb(1'b1, ADR_CTRL, d);
    wb(1'b1, ADR_WDOG, d);
    power_good <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk(proc_reset_oe_o, 1'b1, "power-down reset");
    m_ctrl = d & 32'h1A;
    rd(ADR_CTRL, m_ctrl, "ctrl at power-down");
    rd(ADR_WDOG, 32'h0, "watchdog at power-down");
    wb(1'b1, ADR_CTRL, 32'h1F);
    power_good <= 1'b1;
    @(posedge clk_i);
    oe_len("power cycle pulse");
    m_ctrl = m_ctrl & 32'h02;
    rd(ADR_CTRL, m_ctrl, "ctrl at power-up");
    $display("test power_cycle done");
    // Periodic battery check, flag and interrupt
    wb(1'b1, ADR_IRQ_EN, 32'h1);
    battery_ok <= 1'b0;
    wait_flag(1'b1);
    rd(ADR_FLAGS, 32'h10, "flags register");
    chk(irq, 1'b1, "irq raised");
    wb(1'b1, ADR_IRQ_EN, 32'h0);
    chk(irq, 1'b0, "irq masked");
    wb(1'b1, ADR_IRQ_EN, 32'h1);
    wb(1'b1, ADR_IRQ_CLR, 32'h1);
    chk(irq, 1'b0, "irq cleared");
    battery_ok <= 1'b1;
    repeat (5) @(posedge clk_i);
    chk(flag, 1'b1, "flag sticky");
    wait_flag(1'b0);
    // No checks without main supply; power-up check sees the bad cell
    power_good <= 1'b0;
    battery_ok <= 1'b0;
    repeat (2 * P_CHK + 10) @(posedge clk_i);
    chk(flag, 1'b0, "no check on backup");
    power_good <= 1'b1;
    repeat (4) @(posedge clk_i);
    chk(flag, 1'b1, "power-up check");
    $display("test battery done");
    close_out();
  end
endmodule : rbs_top_bench
